// [pkg/irc_pkg.sv]
// Constants and types for the interrupt request block.
// Assumes a core that reports each instruction end with its code.
package irc_pkg;
  localparam int unsigned ACC_W        = 4;
  localparam int unsigned RLD_W        = 8;
  localparam logic [1:0]  INSTR_LAST   = 2'h2;
  localparam logic [1:0]  INSTR_FIRST  = 2'h0;
  localparam int          CT1_EXT0_EN  = 0;
  localparam int          CT1_EXT1_EN  = 1;
  localparam int          CT2_T4_EN    = 1;
  localparam int          T4C_CNT_PIN  = 3;
  localparam int          T4C_PWM_EXT  = 2;
  localparam int          T4C_RUN      = 1;
  localparam int          T4C_SRC      = 0;
  localparam int          EXC_IN_EN    = 3;
  localparam int          EXC_RISE     = 2;
  localparam int          EXC_BOTH     = 1;
  localparam logic [3:0]  CTRL_RST     = 4'h0;
  localparam logic [7:0]  RLD_RST      = 8'h00;
  typedef enum logic [3:0] {
    IRC_NOP           = 4'h0,
    IRC_DISABLE_ALL   = 4'h1,
    IRC_ENABLE_ALL    = 4'h2,
    IRC_RETURN        = 4'h3,
    IRC_WR_CTRL_ONE   = 4'h4,
    IRC_WR_CTRL_TWO   = 4'h5,
    IRC_WR_T4_CTRL    = 4'h6,
    IRC_WR_PRESC_CTRL = 4'h7,
    IRC_WR_EXT0_CTRL  = 4'h8,
    IRC_WR_EXT1_CTRL  = 4'h9,
    IRC_LD_T4_RELOAD  = 4'hA,
    IRC_LD_PS_RELOAD  = 4'hB,
    IRC_SKIP_T4       = 4'hC,
    IRC_SKIP_EXT0     = 4'hD,
    IRC_SKIP_EXT1     = 4'hE
  } irc_instr_t;
  typedef enum logic [1:0] {
    IRC_SRC_NONE = 2'h0,
    IRC_SRC_EXT0 = 2'h1,
    IRC_SRC_EXT1 = 2'h2,
    IRC_SRC_T4   = 2'h3
  } irc_src_t;
endpackage

// [pkg/irc_links.sv]
// Interfaces between the top of the interrupt block and its counters and pin detectors.
// Assumes one clock domain for all parties.
`timescale 1ns/1ns
`default_nettype none
interface irc_cnt_if #(parameter int unsigned W = 8);
  logic         tick;
  logic         run;
  logic         load;
  logic [W-1:0] reload;
  logic [W-1:0] value;
  logic         underflow;
  modport ctl (output tick, run, load, reload, input value, underflow);
  modport cnt (input tick, run, load, reload, output value, underflow);
endinterface

interface irc_ext_if;
  logic in_en;
  logic rise_pol;
  logic both;
  logic hit;
  modport ctl (output in_en, rise_pol, both, input hit);
  modport det (input in_en, rise_pol, both, output hit);
endinterface
`default_nettype wire

// [rtl/irc_reload_cnt.sv]
// Down counter with reload register value, underflow pulse.
// Assumes tick and load come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module irc_reload_cnt #(
  parameter int unsigned W = 8
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  irc_cnt_if.cnt    bus
);
  logic [W-1:0] cnt_reg;
  logic         uf_reg;
  logic         at_zero;

  assign at_zero = (cnt_reg == '0);
  assign bus.value = cnt_reg;
  assign bus.underflow = uf_reg;

  // Counts n down to 0, so n+1 ticks per underflow
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (ce) begin
      if (bus.load) begin
        cnt_reg <= bus.reload;
      end else if (bus.run && bus.tick) begin
        cnt_reg <= at_zero ? bus.reload : W'(cnt_reg - 1'b1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      uf_reg <= 1'b0;
    end else if (ce) begin
      uf_reg <= !bus.load && bus.run && bus.tick && at_zero;
    end
  end
endmodule
`default_nettype wire

// [rtl/irc_ext_detect.sv]
// Pin synchroniser and valid waveform detector for one external interrupt pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module irc_ext_detect (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic pin,
  irc_ext_if.det    ctl
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic lvl_reg;
  logic prev_reg;
  logic hit_reg;
  logic norm;

  assign ctl.hit = hit_reg;
  // Normalised active level; gating and polarity changes show up as edges
  assign norm = ctl.in_en && (ctl.rise_pol ? lvl_reg : !lvl_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      lvl_reg <= 1'b0;
    end else if (ce) begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        lvl_reg <= s3_reg;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= 1'b0;
      hit_reg <= 1'b0;
    end else if (ce) begin
      prev_reg <= norm;
      hit_reg <= ctl.both ? (norm != prev_reg) : (norm && !prev_reg);
    end
  end
endmodule
`default_nettype wire

// [rtl/irc_top.sv]
// Interrupt request control: global enable, timer4 with prescaler, two external pins.
// Assumes the core presents INSTR_CODE with a one-cycle INSTR_END per instruction.
`timescale 1ns/1ns
`default_nettype none
module irc_top (
  input  wire logic                      MCLK,
  input  wire logic                      RESETN,
  input  wire logic                      CE,
  input  wire logic                      INSTR_END,
  input  wire irc_pkg::irc_instr_t       INSTR_CODE,
  input  wire logic [irc_pkg::ACC_W-1:0] ACC,
  input  wire logic [irc_pkg::RLD_W-1:0] AB_DATA,
  input  wire logic                      EXTERNAL_IRQ_PIN_ZERO,
  input  wire logic                      EXTERNAL_IRQ_PIN_ONE,
  input  wire logic                      COUNTER_PIN_ONE_INPUT,
  output logic                           SKIP,
  output logic                           IRQ_TAKE,
  output irc_pkg::irc_src_t              IRQ_SRC,
  output logic                           GLOBAL_IRQ_ENABLE,
  output logic [irc_pkg::ACC_W-1:0]      IRQ_CONTROL_ONE,
  output logic [irc_pkg::ACC_W-1:0]      IRQ_CONTROL_TWO,
  output logic [irc_pkg::ACC_W-1:0]      TIMER4_CONTROL,
  output logic                           PRESCALER_CONTROL,
  output logic [irc_pkg::ACC_W-1:0]      EXT0_CONTROL,
  output logic [irc_pkg::ACC_W-1:0]      EXT1_CONTROL,
  output logic                           TIMER4_REQUEST_FLAG,
  output logic                           EXT0_REQUEST_FLAG,
  output logic                           EXT1_REQUEST_FLAG,
  output logic [irc_pkg::RLD_W-1:0]      TIMER4_COUNT,
  output logic [irc_pkg::RLD_W-1:0]      PRESCALER_COUNT
);
  import irc_pkg::*;

  function automatic logic is_op(input logic ex, input irc_instr_t code, input irc_instr_t op);
    return ex && (code == op);
  endfunction

  function automatic logic skip_hit(input logic op, input logic en, input logic flag);
    return op && !en && flag;
  endfunction

  logic [ACC_W-1:0] ctrl_one_reg;
  logic [ACC_W-1:0] ctrl_two_reg;
  logic [ACC_W-1:0] t4_ctrl_reg;
  logic             presc_ctrl_reg;
  logic [ACC_W-1:0] ext0_ctrl_reg;
  logic [ACC_W-1:0] ext1_ctrl_reg;
  logic [RLD_W-1:0] t4_reload_reg;
  logic [RLD_W-1:0] presc_reload_reg;
  logic             glob_en_reg;
  logic             ei_hold_reg;
  logic             in_service_reg;
  logic             t4_flag_reg;
  logic             ext0_flag_reg;
  logic             ext1_flag_reg;
  logic             skip_reg;
  logic             take_reg;
  irc_src_t         src_reg;
  logic [1:0]       phase_reg;
  logic             half_reg;
  logic             cp1_reg;
  logic             cp2_reg;
  logic             cp3_reg;
  logic             cp_lvl_reg;
  logic             cp_prev_reg;

  logic exec;
  logic op_disable;
  logic op_enable;
  logic op_return;
  logic op_skip_t4;
  logic op_skip_ext0;
  logic op_skip_ext1;
  logic op_ld_t4;
  logic op_ld_presc;
  logic inst_tick;
  logic cp_rise;
  logic pend_ext0;
  logic pend_ext1;
  logic pend_t4;
  logic can_take;
  logic take_ext0;
  logic take_ext1;
  logic take_t4;
  logic take_any;
  logic skip_next;

  irc_cnt_if #(.W(RLD_W)) presc_bus ();
  irc_cnt_if #(.W(RLD_W)) t4_bus ();
  irc_ext_if              ext0_bus ();
  irc_ext_if              ext1_bus ();

  assign exec = CE && INSTR_END;
  assign op_disable = is_op(exec, INSTR_CODE, IRC_DISABLE_ALL);
  assign op_enable = is_op(exec, INSTR_CODE, IRC_ENABLE_ALL);
  assign op_return = is_op(exec, INSTR_CODE, IRC_RETURN);
  assign op_skip_t4 = is_op(exec, INSTR_CODE, IRC_SKIP_T4);
  assign op_skip_ext0 = is_op(exec, INSTR_CODE, IRC_SKIP_EXT0);
  assign op_skip_ext1 = is_op(exec, INSTR_CODE, IRC_SKIP_EXT1);
  assign op_ld_t4 = is_op(exec, INSTR_CODE, IRC_LD_T4_RELOAD);
  assign op_ld_presc = is_op(exec, INSTR_CODE, IRC_LD_PS_RELOAD);

  // Control registers written from the accumulator
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_one_reg <= CTRL_RST;
      ctrl_two_reg <= CTRL_RST;
      t4_ctrl_reg <= CTRL_RST;
      presc_ctrl_reg <= 1'b0;
      ext0_ctrl_reg <= CTRL_RST;
      ext1_ctrl_reg <= CTRL_RST;
    end else if (exec) begin
      if (INSTR_CODE == IRC_WR_CTRL_ONE) begin
        ctrl_one_reg <= ACC;
      end else if (INSTR_CODE == IRC_WR_CTRL_TWO) begin
        ctrl_two_reg <= ACC;
      end else if (INSTR_CODE == IRC_WR_T4_CTRL) begin
        t4_ctrl_reg <= ACC;
      end else if (INSTR_CODE == IRC_WR_PRESC_CTRL) begin
        presc_ctrl_reg <= ACC[0];
      end else if (INSTR_CODE == IRC_WR_EXT0_CTRL) begin
        ext0_ctrl_reg <= ACC;
      end else if (INSTR_CODE == IRC_WR_EXT1_CTRL) begin
        ext1_ctrl_reg <= ACC;
      end
    end
  end

  // Reload registers written from the data pair
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      t4_reload_reg <= RLD_RST;
      presc_reload_reg <= RLD_RST;
    end else begin
      if (op_ld_t4) begin
        t4_reload_reg <= AB_DATA;
      end
      if (op_ld_presc) begin
        presc_reload_reg <= AB_DATA;
      end
    end
  end

  // Instruction clock is one system clock in three
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      phase_reg <= INSTR_FIRST;
    end else if (CE) begin
      phase_reg <= (phase_reg == INSTR_LAST) ? INSTR_FIRST : 2'(phase_reg + 2'h1);
    end
  end
  assign inst_tick = CE && (phase_reg == INSTR_LAST);

  // Counter pin: three flops, a rise counts once stages two and three agree
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      cp1_reg <= 1'b0;
      cp2_reg <= 1'b0;
      cp3_reg <= 1'b0;
      cp_lvl_reg <= 1'b0;
      cp_prev_reg <= 1'b0;
    end else if (CE) begin
      cp1_reg <= COUNTER_PIN_ONE_INPUT;
      cp2_reg <= cp1_reg;
      cp3_reg <= cp2_reg;
      if (cp2_reg == cp3_reg) begin
        cp_lvl_reg <= cp3_reg;
      end
      cp_prev_reg <= cp_lvl_reg;
    end
  end
  assign cp_rise = cp_lvl_reg && !cp_prev_reg;

  // Halves the prescaler output for the timer4 prescaler source
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      half_reg <= 1'b0;
    end else if (CE && presc_bus.underflow) begin
      half_reg <= !half_reg;
    end
  end

  assign presc_bus.tick = inst_tick;
  assign presc_bus.run = presc_ctrl_reg;
  assign presc_bus.load = op_ld_presc;
  assign presc_bus.reload = op_ld_presc ? AB_DATA : presc_reload_reg;

  irc_reload_cnt #(.W(RLD_W)) u_presc (
    .clk   (MCLK),
    .rst_n (RESETN),
    .ce    (CE),
    .bus   (presc_bus)
  );

  assign t4_bus.tick = t4_ctrl_reg[T4C_SRC] ? (presc_bus.underflow && half_reg)
                                            : (cp_rise && t4_ctrl_reg[T4C_CNT_PIN]);
  assign t4_bus.run = t4_ctrl_reg[T4C_RUN];
  assign t4_bus.load = op_ld_t4;
  assign t4_bus.reload = op_ld_t4 ? AB_DATA : t4_reload_reg;

  irc_reload_cnt #(.W(RLD_W)) u_t4 (
    .clk   (MCLK),
    .rst_n (RESETN),
    .ce    (CE),
    .bus   (t4_bus)
  );

  assign ext0_bus.in_en = ext0_ctrl_reg[EXC_IN_EN];
  assign ext0_bus.rise_pol = ext0_ctrl_reg[EXC_RISE];
  assign ext0_bus.both = ext0_ctrl_reg[EXC_BOTH];
  assign ext1_bus.in_en = ext1_ctrl_reg[EXC_IN_EN];
  assign ext1_bus.rise_pol = ext1_ctrl_reg[EXC_RISE];
  assign ext1_bus.both = ext1_ctrl_reg[EXC_BOTH];

  irc_ext_detect u_ext0 (
    .clk   (MCLK),
    .rst_n (RESETN),
    .ce    (CE),
    .pin   (EXTERNAL_IRQ_PIN_ZERO),
    .ctl   (ext0_bus)
  );

  irc_ext_detect u_ext1 (
    .clk   (MCLK),
    .rst_n (RESETN),
    .ce    (CE),
    .pin   (EXTERNAL_IRQ_PIN_ONE),
    .ctl   (ext1_bus)
  );

  // Acceptance at an instruction end, fixed priority ext0, ext1, timer4
  assign pend_ext0 = ext0_flag_reg && ctrl_one_reg[CT1_EXT0_EN];
  assign pend_ext1 = ext1_flag_reg && ctrl_one_reg[CT1_EXT1_EN];
  assign pend_t4 = t4_flag_reg && ctrl_two_reg[CT2_T4_EN];
  assign can_take = exec && glob_en_reg && !ei_hold_reg && !in_service_reg;
  assign take_ext0 = can_take && pend_ext0;
  assign take_ext1 = can_take && !pend_ext0 && pend_ext1;
  assign take_t4 = can_take && !pend_ext0 && !pend_ext1 && pend_t4;
  assign take_any = take_ext0 || take_ext1 || take_t4;

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      glob_en_reg <= 1'b0;
    end else if (take_any) begin
      glob_en_reg <= 1'b0;
    end else if (op_disable) begin
      glob_en_reg <= 1'b0;
    end else if (op_enable) begin
      glob_en_reg <= 1'b1;
    end
  end

  // Enable waits one instruction end before acceptance may use it
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      ei_hold_reg <= 1'b0;
    end else if (op_enable) begin
      ei_hold_reg <= 1'b1;
    end else if (exec) begin
      ei_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      in_service_reg <= 1'b0;
    end else if (take_any) begin
      in_service_reg <= 1'b1;
    end else if (op_return) begin
      in_service_reg <= 1'b0;
    end
  end

  // Request flags: a set always wins over a clear in the same cycle
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      t4_flag_reg <= 1'b0;
      ext0_flag_reg <= 1'b0;
      ext1_flag_reg <= 1'b0;
    end else if (CE) begin
      if (t4_bus.underflow) begin
        t4_flag_reg <= 1'b1;
      end else if (take_t4 || (op_skip_t4 && !ctrl_two_reg[CT2_T4_EN])) begin
        t4_flag_reg <= 1'b0;
      end
      if (ext0_bus.hit) begin
        ext0_flag_reg <= 1'b1;
      end else if (take_ext0 || (op_skip_ext0 && !ctrl_one_reg[CT1_EXT0_EN])) begin
        ext0_flag_reg <= 1'b0;
      end
      if (ext1_bus.hit) begin
        ext1_flag_reg <= 1'b1;
      end else if (take_ext1 || (op_skip_ext1 && !ctrl_one_reg[CT1_EXT1_EN])) begin
        ext1_flag_reg <= 1'b0;
      end
    end
  end

  assign skip_next = skip_hit(op_skip_t4, ctrl_two_reg[CT2_T4_EN], t4_flag_reg)
                  || skip_hit(op_skip_ext0, ctrl_one_reg[CT1_EXT0_EN], ext0_flag_reg)
                  || skip_hit(op_skip_ext1, ctrl_one_reg[CT1_EXT1_EN], ext1_flag_reg);

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      skip_reg <= 1'b0;
      take_reg <= 1'b0;
      src_reg <= IRC_SRC_NONE;
    end else if (CE) begin
      skip_reg <= skip_next;
      take_reg <= take_any;
      if (take_ext0) begin
        src_reg <= IRC_SRC_EXT0;
      end else if (take_ext1) begin
        src_reg <= IRC_SRC_EXT1;
      end else if (take_t4) begin
        src_reg <= IRC_SRC_T4;
      end
    end
  end

  assign SKIP = skip_reg;
  assign IRQ_TAKE = take_reg;
  assign IRQ_SRC = src_reg;
  assign GLOBAL_IRQ_ENABLE = glob_en_reg;
  assign IRQ_CONTROL_ONE = ctrl_one_reg;
  assign IRQ_CONTROL_TWO = ctrl_two_reg;
  assign TIMER4_CONTROL = t4_ctrl_reg;
  assign PRESCALER_CONTROL = presc_ctrl_reg;
  assign EXT0_CONTROL = ext0_ctrl_reg;
  assign EXT1_CONTROL = ext1_ctrl_reg;
  assign TIMER4_REQUEST_FLAG = t4_flag_reg;
  assign EXT0_REQUEST_FLAG = ext0_flag_reg;
  assign EXT1_REQUEST_FLAG = ext1_flag_reg;
  assign TIMER4_COUNT = t4_bus.value;
  assign PRESCALER_COUNT = presc_bus.value;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  glob_gate_a: assert property (!glob_en_reg |=> !IRQ_TAKE)
    else $error("interrupt taken with global enable low");
  take_clears_a: assert property (take_any |=> !glob_en_reg && in_service_reg)
    else $error("global enable not cleared on acceptance");
  no_nesting_a: assert property (in_service_reg && !IRQ_TAKE |=> !IRQ_TAKE)
    else $error("nested interrupt accepted");
  enable_delay_a: assert property (ei_hold_reg |=> !IRQ_TAKE)
    else $error("enable took effect too early");
  t4_gate_a: assert property (take_t4 |-> ctrl_two_reg[CT2_T4_EN] && t4_flag_reg)
    else $error("timer4 taken while disabled");
  skip_nop_a: assert property (op_skip_t4 && ctrl_two_reg[CT2_T4_EN] |=> !SKIP)
    else $error("skip test not inert while enabled");
  skip_clear_a: assert property (op_skip_t4 && !ctrl_two_reg[CT2_T4_EN] && t4_flag_reg
                                 && !t4_bus.underflow |=> SKIP && !t4_flag_reg)
    else $error("timer4 skip test failed to skip and clear");
  t4_flag_set_a: assert property (CE && t4_bus.underflow |=> t4_flag_reg)
    else $error("timer4 underflow did not set flag");
  t4_reload_a: assert property (CE && t4_bus.run && t4_bus.tick && !op_ld_t4 && t4_bus.value == '0
                                |=> t4_bus.value == $past(t4_reload_reg))
    else $error("timer4 did not reload at zero");
  half_div_a: assert property (CE && presc_bus.underflow && !half_reg && t4_ctrl_reg[T4C_SRC]
                               && !op_ld_t4 |=> $stable(t4_bus.value))
    else $error("timer4 counted on odd prescaler pulse");
  instr_clock_a: assert property (inst_tick |=> !inst_tick ##1 !inst_tick)
    else $error("instruction clock faster than one in three");
  ext0_set_a: assert property (CE && ext0_bus.hit |=> ext0_flag_reg)
    else $error("ext0 waveform did not set flag");
endmodule
`default_nettype wire

// [tb/irc_pin_src.sv]
// Far-side model: two external interrupt sources on shared port pins.
// Assumes the bench commands each pin level; edges land off the clock grid.
`timescale 1ns/1ns
`default_nettype none
module irc_pin_src (
  input  wire logic set0,
  input  wire logic set1,
  output logic      pin0,
  output logic      pin1
);
  // Asynchronous to the system clock, so the synchroniser is exercised
  always @(set0) pin0 <= #7 set0;
  always @(set1) pin1 <= #7 set1;
endmodule
`default_nettype wire

// [tb/interrupt_request_control_tb.sv]
// Bench for the interrupt request block: instruction-level calls and compares.
// Assumes irc_pin_src drives both external pins.
`timescale 1ns/1ns
`default_nettype none
module interrupt_request_control_tb;
  import irc_pkg::*;
  localparam int PS = 1;
  localparam int TR = 1;
  logic       mclk, rst_n, ce, iend, cnt_in, lv0, lv1, skp, tk;
  irc_instr_t code;
  irc_src_t   src;
  logic [3:0] acc;
  logic [7:0] ab;
  wire logic  pin0, pin1, skip_o, take_o, gie, t4f, e0f, e1f;
  wire logic [3:0] t4c, c1o, c2o, e0c, e1c;
  wire logic       pctl;
  wire logic [7:0] t4cnt, pcnt;
  int         miscompares, total_checks, cyc, t0;

  irc_pin_src u_src (.set0(lv0), .set1(lv1), .pin0(pin0), .pin1(pin1));
  irc_top u_dut (
    .MCLK(mclk), .RESETN(rst_n), .CE(ce), .INSTR_END(iend), .INSTR_CODE(code), .ACC(acc), .AB_DATA(ab),
    .EXTERNAL_IRQ_PIN_ZERO(pin0), .EXTERNAL_IRQ_PIN_ONE(pin1), .COUNTER_PIN_ONE_INPUT(cnt_in),
    .SKIP(skip_o), .IRQ_TAKE(take_o), .IRQ_SRC(src), .GLOBAL_IRQ_ENABLE(gie), .IRQ_CONTROL_ONE(c1o),
    .IRQ_CONTROL_TWO(c2o), .TIMER4_CONTROL(t4c), .PRESCALER_CONTROL(pctl), .EXT0_CONTROL(e0c),
    .EXT1_CONTROL(e1c), .TIMER4_REQUEST_FLAG(t4f), .EXT0_REQUEST_FLAG(e0f), .EXT1_REQUEST_FLAG(e1f),
    .TIMER4_COUNT(t4cnt), .PRESCALER_COUNT(pcnt)
  );

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) cyc++;

  task automatic test_done();
    if (miscompares == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
    end
  endtask

  // One instruction end, three cycles apart; answer pulses caught a cycle later
  task automatic op(input irc_instr_t c, input logic [3:0] a, input logic [7:0] b);
    @(negedge mclk);
    iend = 1'b1;
    code = c;
    acc = a;
    ab = b;
    @(negedge mclk);
    iend = 1'b0;
    skp = skip_o;
    tk = take_o;
    @(negedge mclk);
  endtask

  task automatic wait_t4();
    int n;
    n = 0;
    while (t4f !== 1'b1 && n < 300) begin
      @(negedge mclk);
      n++;
    end
    chk("t4 flag wait", 8'h00, (n == 300) ? 8'h01 : 8'h00);
  endtask

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    iend = 1'b0;
    code = IRC_NOP;
    acc = 4'h0;
    ab = 8'h00;
    cnt_in = 1'b0;
    lv0 = 1'b0;
    lv1 = 1'b1;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    chk("reset flags", 8'h00, {gie, t4f, e0f, e1f});
    op(IRC_DISABLE_ALL, 4'h0, 8'h00);
    op(IRC_WR_CTRL_TWO, 4'h0, 8'h00);
    op(IRC_WR_T4_CTRL, 4'h0, 8'h00);
    op(IRC_WR_PRESC_CTRL, 4'h0, 8'h00);
    op(IRC_LD_T4_RELOAD, 4'h0, 8'(TR));
    op(IRC_LD_PS_RELOAD, 4'h0, 8'(PS));
    op(IRC_SKIP_T4, 4'h0, 8'h00);
    op(IRC_WR_T4_CTRL, 4'h3, 8'h00);
    op(IRC_WR_PRESC_CTRL, 4'h1, 8'h00);
    chk("t4 control", 8'h03, t4c);
    wait_t4();
    op(IRC_SKIP_T4, 4'h0, 8'h00);
    wait_t4();
    t0 = cyc;
    op(IRC_SKIP_T4, 4'h0, 8'h00);
    chk("t4 skip", 8'h01, skp);
    chk("t4 flag clr", 8'h00, t4f);
    wait_t4();
    chk("t4 period", 8'(3 * (PS + 1) * 2 * (TR + 1)), 8'(cyc - t0));
    op(IRC_WR_CTRL_TWO, 4'h2, 8'h00);
    op(IRC_SKIP_T4, 4'h0, 8'h00);
    chk("t4 skip nop", 8'h01, {skp, t4f});
    op(IRC_WR_CTRL_TWO, 4'h0, 8'h00);
    op(IRC_WR_EXT0_CTRL, 4'h8, 8'h00);
    op(IRC_NOP, 4'h0, 8'h00);
    chk("ext0 on cfg", 8'h01, e0f);
    op(IRC_SKIP_EXT0, 4'h0, 8'h00);
    chk("ext0 skip", 8'h02, {skp, e0f});
    op(IRC_WR_EXT0_CTRL, 4'hC, 8'h00);
    op(IRC_NOP, 4'h0, 8'h00);
    op(IRC_SKIP_EXT0, 4'h0, 8'h00);
    lv0 = 1'b1;
    repeat (10) @(negedge mclk);
    chk("ext0 rise", 8'h01, e0f);
    op(IRC_WR_EXT0_CTRL, 4'hE, 8'h00);
    op(IRC_NOP, 4'h0, 8'h00);
    op(IRC_SKIP_EXT0, 4'h0, 8'h00);
    lv0 = 1'b0;
    repeat (10) @(negedge mclk);
    chk("ext0 both", 8'h01, e0f);
    op(IRC_WR_CTRL_ONE, 4'h1, 8'h00);
    op(IRC_ENABLE_ALL, 4'h0, 8'h00);
    op(IRC_NOP, 4'h0, 8'h00);
    chk("take early", 8'h00, tk);
    op(IRC_NOP, 4'h0, 8'h00);
    chk("take", 8'h01, tk);
    chk("take src", IRC_SRC_EXT0, src);
    chk("take gie", 8'h00, {gie, e0f});
    lv0 = 1'b1;
    repeat (10) @(negedge mclk);
    op(IRC_ENABLE_ALL, 4'h0, 8'h00);
    op(IRC_NOP, 4'h0, 8'h00);
    op(IRC_NOP, 4'h0, 8'h00);
    chk("nested", 8'h00, tk);
    op(IRC_ENABLE_ALL, 4'h0, 8'h00);
    op(IRC_RETURN, 4'h0, 8'h00);
    chk("take at ret", 8'h00, tk);
    op(IRC_NOP, 4'h0, 8'h00);
    chk("take after ret", 8'h01, tk);
    op(IRC_RETURN, 4'h0, 8'h00);
    lv0 = 1'b0;
    repeat (10) @(negedge mclk);
    op(IRC_NOP, 4'h0, 8'h00);
    op(IRC_NOP, 4'h0, 8'h00);
    chk("gie off", 8'h00, tk);
    op(IRC_WR_EXT1_CTRL, 4'h8, 8'h00);
    lv1 = 1'b0;
    repeat (10) @(negedge mclk);
    chk("ext1 fall", 8'h01, e1f);
    op(IRC_SKIP_EXT1, 4'h0, 8'h00);
    chk("ext1 skip", 8'h02, {skp, e1f});
    op(IRC_WR_EXT1_CTRL, 4'h0, 8'h00);
    op(IRC_NOP, 4'h0, 8'h00);
    op(IRC_SKIP_EXT1, 4'h0, 8'h00);
    op(IRC_WR_EXT1_CTRL, 4'h8, 8'h00);
    op(IRC_NOP, 4'h0, 8'h00);
    chk("ext1 on cfg", 8'h01, e1f);
    chk("irq ctrl regs", 8'h10, {c1o, c2o});
    chk("ext ctrl regs", 8'hE8, {e0c, e1c});
    op(IRC_WR_PRESC_CTRL, 4'h0, 8'h00);
    chk("presc ctrl", 8'h00, pctl);
    op(IRC_LD_PS_RELOAD, 4'h0, 8'h05);
    chk("presc count", 8'h05, pcnt);
    op(IRC_WR_T4_CTRL, 4'hA, 8'h00);
    op(IRC_LD_T4_RELOAD, 4'h0, 8'h02);
    chk("t4 count load", 8'h02, t4cnt);
    cnt_in = 1'b1;
    repeat (10) @(negedge mclk);
    chk("t4 pin count", 8'h01, t4cnt);
    test_done();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
